// ==== rtl/cbb_pkg.sv ====
// Shared constants, opcodes and types of the branch and boolean core
package cbb_pkg;

  // ----------------------------------------------------------------
  // Core registers in the direct address space
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_STACK_TOP = 8'h81;
  localparam logic [7:0] SFR_PTR_LOW = 8'h82;
  localparam logic [7:0] SFR_PTR_HIGH = 8'h83;
  localparam logic [7:0] SFR_ACCUM = 8'hE0;
  localparam logic [7:0] STACK_TOP_RST = 8'h07;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [3:0] BIT_RAM_BASE = 4'h2;
  localparam logic [1:0] WAIT_MAX_DEF = 2'h2;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_IDLE = 8'h00;
  localparam logic [7:0] OP_IDLE_ALT = 8'hA5;
  localparam logic [7:0] OP_BIT_SET_CY = 8'hD3;
  localparam logic [7:0] OP_BIT_SET_DIR = 8'hD2;
  localparam logic [7:0] OP_BIT_INV_CY = 8'hB3;
  localparam logic [7:0] OP_BIT_INV_DIR = 8'hB2;
  localparam logic [7:0] OP_AND_CY_BIT = 8'h82;
  localparam logic [7:0] OP_AND_CY_NBIT = 8'hB0;
  localparam logic [7:0] OP_OR_CY_BIT = 8'h72;
  localparam logic [7:0] OP_OR_CY_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOVE_BIT_CY = 8'hA2;
  localparam logic [7:0] OP_MOVE_CY_BIT = 8'h92;
  localparam logic [7:0] OP_BR_CY = 8'h40;
  localparam logic [7:0] OP_BR_NCY = 8'h50;
  localparam logic [7:0] OP_BR_BIT = 8'h20;
  localparam logic [7:0] OP_BR_NBIT = 8'h30;
  localparam logic [7:0] OP_BR_BIT_CLR = 8'h10;
  localparam logic [4:0] OP_PAGE_CALL = 5'h11;
  localparam logic [4:0] OP_PAGE_JUMP = 5'h01;
  localparam logic [7:0] OP_FAR_CALL = 8'h12;
  localparam logic [7:0] OP_FAR_JUMP = 8'h02;
  localparam logic [7:0] OP_SUB_EXIT = 8'h22;
  localparam logic [7:0] OP_IRQ_EXIT = 8'h32;
  localparam logic [7:0] OP_SHORT_BR = 8'h80;
  localparam logic [7:0] OP_JUMP_IND = 8'h73;
  localparam logic [7:0] OP_BR_ZERO = 8'h60;
  localparam logic [7:0] OP_BR_NZERO = 8'h70;
  localparam logic [7:0] OP_CMP_ACC_DIR = 8'hB5;
  localparam logic [7:0] OP_CMP_ACC_IMM = 8'hB4;
  localparam logic [6:0] OP_CMP_IDX = 7'h5B;
  localparam logic [4:0] OP_CMP_BANK = 5'h17;
  localparam logic [4:0] OP_COUNT_BANK = 5'h1B;
  localparam logic [7:0] OP_COUNT_DIR = 8'hD5;

  // ----------------------------------------------------------------
  // Instruction classes and their timing
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CL_IDLE, CL_CY, CL_BIT, CL_BR_CY, CL_BR_BIT, CL_PCALL, CL_PJUMP,
    CL_FCALL, CL_FJUMP, CL_EXIT, CL_SHORT, CL_IND, CL_BR_ACC,
    CL_CMP_AD, CL_CMP_AI, CL_CMP_RN, CL_CMP_RI, CL_CNT_RN, CL_CNT_D
  } cbb_cls_t;

  // Byte count, step of decision, last step when taken, branch kind
  typedef struct packed {
    logic [1:0] nbytes;
    logic [2:0] eval;
    logic [2:0] last;
    logic branch;
  } cbb_time_t;

  // Last step of a taken branch excludes the flash wait cycles
  function automatic cbb_time_t cbb_timing(input cbb_cls_t cls);
    case (cls)
      CL_BIT: return '{2'h2, 3'h1, 3'h1, 1'b0};
      CL_BR_CY, CL_PCALL, CL_PJUMP, CL_SHORT, CL_BR_ACC, CL_CNT_RN:
        return '{2'h2, 3'h1, 3'h3, 1'b1};
      CL_BR_BIT, CL_FCALL, CL_FJUMP, CL_CMP_RN, CL_CNT_D:
        return '{2'h3, 3'h2, 3'h4, 1'b1};
      CL_EXIT: return '{2'h1, 3'h2, 3'h5, 1'b1};
      CL_IND: return '{2'h1, 3'h0, 3'h2, 1'b1};
      CL_CMP_AD, CL_CMP_RI: return '{2'h3, 3'h3, 3'h5, 1'b1};
      CL_CMP_AI: return '{2'h3, 3'h2, 3'h5, 1'b1};
      default: return '{2'h1, 3'h0, 3'h0, 1'b0};
    endcase
  endfunction

endpackage

// ==== rtl/cbb_regs.sv ====
// Stack top, data pointer and accumulator registers of the core
module cbb_regs (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic direct_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic push_i,
  input wire logic pop_i,
  output logic hit_o,
  output logic [7:0] rdata_o,
  output logic [7:0] stack_top_o,
  output logic [15:0] ptr_o,
  output logic [7:0] accum_o
);

  logic [7:0] stack_top_q;
  logic [7:0] ptr_low_q;
  logic [7:0] ptr_high_q;
  logic [7:0] accum_q;
  logic hit_sp_w;
  logic hit_dl_w;
  logic hit_dh_w;
  logic hit_acc_w;

  // ---------------------------------------------------------------
  // Address decode; indirect accesses never reach these registers
  // ---------------------------------------------------------------
  assign hit_sp_w = direct_i && (addr_i == cbb_pkg::SFR_STACK_TOP);
  assign hit_dl_w = direct_i && (addr_i == cbb_pkg::SFR_PTR_LOW);
  assign hit_dh_w = direct_i && (addr_i == cbb_pkg::SFR_PTR_HIGH);
  assign hit_acc_w = direct_i && (addr_i == cbb_pkg::SFR_ACCUM);
  assign hit_o = hit_sp_w || hit_dl_w || hit_dh_w || hit_acc_w;
  assign rdata_o = hit_sp_w ? stack_top_q :
                   hit_dl_w ? ptr_low_q :
                   hit_dh_w ? ptr_high_q :
                   hit_acc_w ? accum_q : 8'h00;
  assign stack_top_o = stack_top_q;
  assign ptr_o = {ptr_high_q, ptr_low_q};
  assign accum_o = accum_q;

  // Stack top: push and pop never meet a direct write in one cycle
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      stack_top_q <= cbb_pkg::STACK_TOP_RST;
    end else if (push_i) begin
      stack_top_q <= stack_top_q + 8'h01;
    end else if (pop_i) begin
      stack_top_q <= stack_top_q - 8'h01;
    end else if (wr_i && hit_sp_w) begin
      stack_top_q <= wdata_i;
    end
  end

  // Pointer halves and accumulator, byte writes only
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ptr_low_q <= cbb_pkg::PTR_RST;
      ptr_high_q <= cbb_pkg::PTR_RST;
      accum_q <= cbb_pkg::ACCUM_RST;
    end else if (wr_i) begin
      if (hit_dl_w) ptr_low_q <= wdata_i;
      if (hit_dh_w) ptr_high_q <= wdata_i;
      if (hit_acc_w) accum_q <= wdata_i;
    end
  end

endmodule

// ==== rtl/cbb_core.sv ====
// Sequencer for boolean-on-carry and program branching instructions

// How it works
// - Direct bit with carry forms take two bytes and two clocks.
// - Set and invert of carry alone take one byte, one clock.
// - Carry branches: two bytes, two clocks idle, four to six taken.
// - Bit branches: three bytes, three or five to seven; clear variant clears bit.
// - Page call and jump replace low eleven bits of next address.
// - Far call and jump load a full sixteen-bit target, five to seven clocks.
// - Subroutine and interrupt exits are one byte, six to eight clocks.
// - Relative offset is signed, added to address of the next instruction.
// - Indirect jump goes to accumulator plus pointer, three to five clocks.
// - Accumulator zero branches test for zero, two or four to six clocks.
// - Compare branch jumps when operands differ; three bytes, listed counts.
// - Count-down branch decrements register or byte, jumps while nonzero.
// - Idle opcode and spare opcode both take one byte, one clock.
// - Taken counts stretch within ranges by the flash read timing setting.
// - Bank operands pick R0-R7 of current bank; indirect uses R0 or R1.
// - Direct addresses below 0x80 hit data RAM, above hit SFRs.
// - Pointer low and high bytes form the indirect pointer, both reset zero.
// - Stack top increments before each stored byte.
// - Stack top resets to 0x07.
// - Accumulator sits at its SFR address, bit addressable, resets zero.
// - Two-bit bank select picks one of four eight-byte banks.
module cbb_core #(
  parameter int unsigned WAIT_MAX = 2
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  output logic [15:0] code_addr_o,
  output logic code_rd_o,
  input wire logic [7:0] code_data_i,
  output logic [7:0] data_addr_o,
  output logic data_rd_o,
  output logic data_wr_o,
  output logic [7:0] data_wdata_o,
  output logic data_sfr_o,
  input wire logic [7:0] data_rdata_i,
  input wire logic carry_i,
  output logic carry_wr_o,
  output logic carry_o,
  input wire logic [1:0] bank_select_i,
  input wire logic [1:0] flash_read_timing_i,
  output logic instr_end_o,
  output logic irq_exit_o,
  output logic [7:0] stack_top_o,
  output logic [15:0] indirect_pointer_o,
  output logic [7:0] arith_result_o
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  // Wait count extra_w is two bits wide: no more than 3 waits can be added
  if (WAIT_MAX > 3) begin : g_bad_wait
    $error("WAIT_MAX above 3 cannot be served");
  end

  typedef enum logic [2:0] {
    WK_NONE, WK_BIT, WK_DEC, WK_PUSH_LO, WK_PUSH_HI
  } cbb_wkind_t;

  logic [15:0] pc_q;
  logic [3:0] step_q;
  logic [3:0] last_q;
  logic [7:0] opc_q;
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  logic [7:0] ptr_q;
  logic [7:0] hi_q;
  logic [15:0] tgt_q;
  logic [15:0] ret_q;
  cbb_pkg::cbb_cls_t cls_q;

  cbb_pkg::cbb_cls_t cls_w;
  cbb_pkg::cbb_time_t tm_w;
  logic [7:0] opc_w;
  logic [7:0] b1_w;
  logic [7:0] b2_w;
  logic [7:0] rel_w;
  logic fetch_w;
  logic at_eval_w;
  logic past_eval_w;
  logic go_w;
  logic taken_w;
  logic fin_w;
  logic [15:0] pc_seq_w;
  logic [15:0] rel_tgt_w;
  logic [15:0] target_w;
  logic [1:0] extra_w;
  logic [7:0] acc_addr;
  logic acc_rd;
  logic acc_ind;
  cbb_wkind_t acc_kind;
  logic regs_hit_w;
  logic [7:0] regs_rdata_w;
  logic [7:0] rd_w;
  logic [7:0] bit_byte_w;
  logic [7:0] bit_mask_w;
  logic bit_val_w;
  logic bit_new_w;
  logic bit_wr_w;
  logic wr_w;
  logic [7:0] wdata_w;
  logic [7:0] dec_w;
  logic [7:0] cmp_a_w;
  logic [7:0] cmp_b_w;
  logic [7:0] bank_rn_w;
  logic [7:0] bank_ri_w;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Anything outside this block's set runs as a one-clock idle
  function automatic cbb_pkg::cbb_cls_t decode(input logic [7:0] op);
    if (op[4:0] == cbb_pkg::OP_PAGE_CALL) return cbb_pkg::CL_PCALL;
    if (op[4:0] == cbb_pkg::OP_PAGE_JUMP) return cbb_pkg::CL_PJUMP;
    if (op[7:1] == cbb_pkg::OP_CMP_IDX) return cbb_pkg::CL_CMP_RI;
    if (op[7:3] == cbb_pkg::OP_CMP_BANK) return cbb_pkg::CL_CMP_RN;
    if (op[7:3] == cbb_pkg::OP_COUNT_BANK) return cbb_pkg::CL_CNT_RN;
    case (op)
      cbb_pkg::OP_BIT_SET_CY, cbb_pkg::OP_BIT_INV_CY:
        return cbb_pkg::CL_CY;
      cbb_pkg::OP_BIT_SET_DIR, cbb_pkg::OP_BIT_INV_DIR,
      cbb_pkg::OP_AND_CY_BIT, cbb_pkg::OP_AND_CY_NBIT,
      cbb_pkg::OP_OR_CY_BIT, cbb_pkg::OP_OR_CY_NBIT,
      cbb_pkg::OP_MOVE_BIT_CY, cbb_pkg::OP_MOVE_CY_BIT:
        return cbb_pkg::CL_BIT;
      cbb_pkg::OP_BR_CY, cbb_pkg::OP_BR_NCY: return cbb_pkg::CL_BR_CY;
      cbb_pkg::OP_BR_BIT, cbb_pkg::OP_BR_NBIT, cbb_pkg::OP_BR_BIT_CLR:
        return cbb_pkg::CL_BR_BIT;
      cbb_pkg::OP_FAR_CALL: return cbb_pkg::CL_FCALL;
      cbb_pkg::OP_FAR_JUMP: return cbb_pkg::CL_FJUMP;
      cbb_pkg::OP_SUB_EXIT, cbb_pkg::OP_IRQ_EXIT: return cbb_pkg::CL_EXIT;
      cbb_pkg::OP_SHORT_BR: return cbb_pkg::CL_SHORT;
      cbb_pkg::OP_JUMP_IND: return cbb_pkg::CL_IND;
      cbb_pkg::OP_BR_ZERO, cbb_pkg::OP_BR_NZERO: return cbb_pkg::CL_BR_ACC;
      cbb_pkg::OP_CMP_ACC_DIR: return cbb_pkg::CL_CMP_AD;
      cbb_pkg::OP_CMP_ACC_IMM: return cbb_pkg::CL_CMP_AI;
      cbb_pkg::OP_COUNT_DIR: return cbb_pkg::CL_CNT_D;
      default: return cbb_pkg::CL_IDLE;
    endcase
  endfunction

  // Step 0 decodes the opcode straight off the code bus
  assign opc_w = (step_q == 4'h0) ? code_data_i : opc_q;
  assign cls_w = (step_q == 4'h0) ? decode(code_data_i) : cls_q;
  assign tm_w = cbb_pkg::cbb_timing(cls_w);
  assign b1_w = (step_q == 4'h1) ? code_data_i : b1_q;
  assign b2_w = (step_q == 4'h2) ? code_data_i : b2_q;

  // ---------------------------------------------------------------
  // Step control
  // ---------------------------------------------------------------
  assign fetch_w = step_q < {2'h0, tm_w.nbytes};
  assign at_eval_w = step_q == {1'b0, tm_w.eval};
  assign past_eval_w = step_q > {1'b0, tm_w.eval};
  assign pc_seq_w = fetch_w ? pc_q + 16'h0001 : pc_q;
  assign go_w = tm_w.branch && taken_w;
  assign fin_w = at_eval_w ? !go_w : (past_eval_w && step_q == last_q);
  assign extra_w = (flash_read_timing_i > 2'(WAIT_MAX)) ?
                   2'(WAIT_MAX) : flash_read_timing_i;
  assign code_addr_o = pc_q;
  assign code_rd_o = fetch_w;
  assign instr_end_o = fin_w;
  assign irq_exit_o = fin_w && (opc_w == cbb_pkg::OP_IRQ_EXIT);

  // ---------------------------------------------------------------
  // Targets
  // ---------------------------------------------------------------
  // Offset is the last instruction byte, sign extended
  assign rel_w = (tm_w.nbytes == 2'h2) ? b1_w : b2_w;
  assign rel_tgt_w = pc_seq_w + {{8{rel_w[7]}}, rel_w};
  always_comb begin
    case (cls_w)
      cbb_pkg::CL_PCALL, cbb_pkg::CL_PJUMP:
        target_w = {pc_seq_w[15:11], opc_w[7:5], b1_w};
      cbb_pkg::CL_FCALL, cbb_pkg::CL_FJUMP:
        target_w = {b1_w, b2_w};
      cbb_pkg::CL_EXIT: target_w = {hi_q, rd_w};
      cbb_pkg::CL_IND:
        target_w = {8'h00, arith_result_o} + indirect_pointer_o;
      default: target_w = rel_tgt_w;
    endcase
  end

  // ---------------------------------------------------------------
  // Conditions
  // ---------------------------------------------------------------
  assign dec_w = rd_w - 8'h01;
  assign cmp_a_w = (cls_w == cbb_pkg::CL_CMP_AD ||
                    cls_w == cbb_pkg::CL_CMP_AI) ? arith_result_o : rd_w;
  assign cmp_b_w = (cls_w == cbb_pkg::CL_CMP_AD) ? rd_w : b1_w;
  always_comb begin
    case (cls_w)
      cbb_pkg::CL_BR_CY: taken_w = carry_i ^ opc_w[4];
      cbb_pkg::CL_BR_BIT:
        taken_w = (opc_w == cbb_pkg::OP_BR_NBIT) ? !bit_val_w
                                                   : bit_val_w;
      cbb_pkg::CL_BR_ACC:
        taken_w = (arith_result_o == 8'h00) ^ opc_w[4];
      cbb_pkg::CL_CMP_AD, cbb_pkg::CL_CMP_AI, cbb_pkg::CL_CMP_RN,
      cbb_pkg::CL_CMP_RI: taken_w = cmp_a_w != cmp_b_w;
      cbb_pkg::CL_CNT_RN, cbb_pkg::CL_CNT_D:
        taken_w = dec_w != 8'h00;
      default: taken_w = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // Data access per step
  // ---------------------------------------------------------------
  assign bank_rn_w = {3'h0, bank_select_i, opc_w[2:0]};
  assign bank_ri_w = {3'h0, bank_select_i, 2'h0, opc_w[0]};
  // Bit area 0x20-0x2F below 0x80, SFR bits on eight-aligned bytes
  assign bit_byte_w = b1_w[7] ? {b1_w[7:3], 3'h0}
                              : {cbb_pkg::BIT_RAM_BASE, b1_w[6:3]};
  always_comb begin
    acc_addr = 8'h00;
    acc_rd = 1'b0;
    acc_ind = 1'b0;
    acc_kind = WK_NONE;
    case (cls_w)
      cbb_pkg::CL_BIT, cbb_pkg::CL_BR_BIT: begin
        acc_addr = bit_byte_w;
        acc_rd = at_eval_w;
        acc_kind = at_eval_w ? WK_BIT : WK_NONE;
      end
      cbb_pkg::CL_CMP_AD, cbb_pkg::CL_CMP_RN: begin
        acc_addr = (cls_w == cbb_pkg::CL_CMP_AD) ? b1_w : bank_rn_w;
        acc_rd = at_eval_w;
      end
      cbb_pkg::CL_CMP_RI: begin
        // Pointer register first, then the byte it points at
        acc_addr = at_eval_w ? ptr_q : bank_ri_w;
        acc_ind = at_eval_w;
        acc_rd = at_eval_w || step_q == 4'h1;
      end
      cbb_pkg::CL_CNT_RN, cbb_pkg::CL_CNT_D: begin
        acc_addr = (cls_w == cbb_pkg::CL_CNT_D) ? b1_w : bank_rn_w;
        acc_rd = at_eval_w;
        acc_kind = at_eval_w ? WK_DEC : WK_NONE;
      end
      cbb_pkg::CL_PCALL, cbb_pkg::CL_FCALL: begin
        acc_addr = stack_top_o + 8'h01;
        acc_ind = 1'b1;
        if (step_q == {1'b0, tm_w.eval} + 4'h1) acc_kind = WK_PUSH_LO;
        if (step_q == {1'b0, tm_w.eval} + 4'h2) acc_kind = WK_PUSH_HI;
      end
      cbb_pkg::CL_EXIT: begin
        acc_addr = stack_top_o;
        acc_ind = 1'b1;
        acc_rd = step_q == 4'h1 || step_q == 4'h2;
      end
      default: acc_kind = WK_NONE;
    endcase
  end

  // Internal registers answer direct accesses, the rest go out
  cbb_regs u_regs (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .addr_i(acc_addr),
    .direct_i(!acc_ind),
    .wr_i(wr_w),
    .wdata_i(wdata_w),
    .push_i(acc_kind == WK_PUSH_LO || acc_kind == WK_PUSH_HI),
    .pop_i(cls_w == cbb_pkg::CL_EXIT && acc_rd),
    .hit_o(regs_hit_w),
    .rdata_o(regs_rdata_w),
    .stack_top_o(stack_top_o),
    .ptr_o(indirect_pointer_o),
    .accum_o(arith_result_o)
  );

  assign rd_w = regs_hit_w ? regs_rdata_w : data_rdata_i;
  assign bit_mask_w = 8'h01 << b1_w[2:0];
  assign bit_val_w = (rd_w & bit_mask_w) != 8'h00;
  // Only set, invert, move-to-bit and a set tested bit store back
  assign bit_new_w = (opc_w == cbb_pkg::OP_BIT_SET_DIR) ? 1'b1 :
                     (opc_w == cbb_pkg::OP_BIT_INV_DIR) ? !bit_val_w :
                     (opc_w == cbb_pkg::OP_MOVE_CY_BIT) ? carry_i : 1'b0;
  assign bit_wr_w = (opc_w == cbb_pkg::OP_BIT_SET_DIR) ||
                    (opc_w == cbb_pkg::OP_BIT_INV_DIR) ||
                    (opc_w == cbb_pkg::OP_MOVE_CY_BIT) ||
                    (opc_w == cbb_pkg::OP_BR_BIT_CLR && bit_val_w);
  assign wr_w = (acc_kind == WK_BIT) ? bit_wr_w : (acc_kind != WK_NONE);
  assign wdata_w = (acc_kind == WK_BIT) ?
                     (bit_new_w ? rd_w | bit_mask_w : rd_w & ~bit_mask_w) :
                   (acc_kind == WK_DEC) ? dec_w :
                   (acc_kind == WK_PUSH_LO) ? ret_q[7:0] : ret_q[15:8];
  assign data_addr_o = acc_addr;
  assign data_rd_o = acc_rd && !regs_hit_w;
  assign data_wr_o = wr_w && !regs_hit_w;
  assign data_wdata_o = wdata_w;
  assign data_sfr_o = !acc_ind && acc_addr[7];

  // ---------------------------------------------------------------
  // Carry updates
  // ---------------------------------------------------------------
  always_comb begin
    carry_wr_o = 1'b0;
    carry_o = carry_i;
    case (opc_w)
      cbb_pkg::OP_BIT_SET_CY: carry_o = 1'b1;
      cbb_pkg::OP_BIT_INV_CY: carry_o = !carry_i;
      cbb_pkg::OP_AND_CY_BIT: carry_o = carry_i & bit_val_w;
      cbb_pkg::OP_AND_CY_NBIT: carry_o = carry_i & !bit_val_w;
      cbb_pkg::OP_OR_CY_BIT: carry_o = carry_i | bit_val_w;
      cbb_pkg::OP_OR_CY_NBIT: carry_o = carry_i | !bit_val_w;
      cbb_pkg::OP_MOVE_BIT_CY: carry_o = bit_val_w;
      default: carry_o = cmp_a_w < cmp_b_w;
    endcase
    if (at_eval_w) begin
      case (cls_w)
        cbb_pkg::CL_CY: carry_wr_o = 1'b1;
        cbb_pkg::CL_BIT: carry_wr_o = !bit_wr_w;
        cbb_pkg::CL_CMP_AD, cbb_pkg::CL_CMP_AI, cbb_pkg::CL_CMP_RN,
        cbb_pkg::CL_CMP_RI: carry_wr_o = 1'b1;
        default: carry_wr_o = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------
  // Program counter: next byte, or the target on a taken last step
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pc_q <= cbb_pkg::PC_RST;
      step_q <= 4'h0;
    end else begin
      pc_q <= (fin_w && !at_eval_w) ? tgt_q : pc_seq_w;
      step_q <= fin_w ? 4'h0 : step_q + 4'h1;
    end
  end

  // Instruction bytes captured as they stream in
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      opc_q <= 8'h00;
      cls_q <= cbb_pkg::CL_IDLE;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
    end else begin
      opc_q <= opc_w;
      cls_q <= cls_w;
      b1_q <= b1_w;
      b2_q <= b2_w;
    end
  end

  // Decision step fixes the target and the length of the taken path
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tgt_q <= 16'h0000;
      ret_q <= 16'h0000;
      last_q <= 4'h0;
      ptr_q <= 8'h00;
      hi_q <= 8'h00;
    end else begin
      if (at_eval_w) begin
        tgt_q <= target_w;
        ret_q <= pc_seq_w;
        last_q <= {1'b0, tm_w.last} + {2'h0, extra_w};
      end
      if (cls_w == cbb_pkg::CL_CMP_RI && step_q == 4'h1) ptr_q <= rd_w;
      if (cls_w == cbb_pkg::CL_EXIT && step_q == 4'h1) hi_q <= rd_w;
    end
  end

endmodule

// ==== dv/cbb_core_sva.sv ====
// Port-level assertions for the branch and boolean core
module cbb_core_sva #(
  parameter int unsigned WAIT_MAX = 2
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] code_data_i,
  input wire logic [7:0] data_addr_o,
  input wire logic data_sfr_o,
  input wire logic carry_i,
  input wire logic carry_wr_o,
  input wire logic carry_o,
  input wire logic [1:0] flash_read_timing_i,
  input wire logic instr_end_o,
  input wire logic irq_exit_o,
  input wire logic [7:0] stack_top_o,
  input wire logic [15:0] indirect_pointer_o,
  input wire logic [7:0] arith_result_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic start_q;
  logic fast;
  // First cycle of an instruction; reset release counts as one
  always_ff @(posedge clock_i) start_q <= !resetn_i || instr_end_o;
  // Timing checks only where no flash wait stretches the count
  assign fast = flash_read_timing_i == 2'h0;
  AST_IDLE_ONE:
  assert property (start_q && code_data_i inside {8'h00, 8'hA5}
    |-> instr_end_o) else $error("idle opcode not one clock");
  AST_SET_CY:
  assert property (start_q && code_data_i == 8'hD3
    |-> carry_wr_o && carry_o && instr_end_o) else $error("carry set bad");
  AST_INV_CY:
  assert property (start_q && code_data_i == 8'hB3
    |-> carry_wr_o && carry_o != carry_i) else $error("carry invert bad");
  AST_JC_SKIP:
  assert property (start_q && code_data_i == 8'h40 && !carry_i
    |=> instr_end_o) else $error("untaken carry branch not two clocks");
  AST_FAR_TIME:
  assert property (start_q && code_data_i == 8'h02 && fast
    |-> !instr_end_o [*4] ##1 instr_end_o) else $error("far jump count");
  AST_EXIT_TIME:
  assert property (start_q && code_data_i == 8'h22 && fast
    |-> ##5 instr_end_o) else $error("return count wrong");
  AST_IRQ_END:
  assert property (start_q && code_data_i == 8'h32 && fast
    |-> !irq_exit_o [*5] ##1 irq_exit_o && instr_end_o)
    else $error("interrupt exit pulse outside last cycle");
  AST_SFR_SPACE:
  assert property (data_sfr_o |-> data_addr_o[7])
    else $error("low direct address sent to register space");
  AST_REG_RESET:
  assert property ($rose(resetn_i) |-> stack_top_o == 8'h07
    && indirect_pointer_o == 16'h0000 && arith_result_o == 8'h00)
    else $error("core registers not at reset values");
  cover property (irq_exit_o);
  cover property (carry_wr_o && carry_o);
  cover property (start_q && code_data_i == 8'h12);
endmodule

bind cbb_core cbb_core_sva #(.WAIT_MAX(WAIT_MAX)) chk (.*);

// ==== dv/cbb_mem.sv ====
// Program memory and data RAM model beside the core
module cbb_mem (
  input wire logic clock_i,
  input wire logic [15:0] code_addr_i,
  output logic [7:0] code_data_o,
  input wire logic [7:0] data_addr_i,
  input wire logic data_rd_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  output logic [7:0] data_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rom [65536];
  logic [7:0] ram [256];
  // Unwritten program space reads as idle opcodes
  initial foreach (rom[i]) rom[i] = 8'h00;
  initial foreach (ram[i]) ram[i] = 8'h00;
  // Reads answer at once; an idle data bus shows the inverse byte
  assign code_data_o = rom[code_addr_i];
  assign data_rdata_o = data_rd_i ? ram[data_addr_i] : ~ram[data_addr_i];
  // Writes land on the clock edge
  always @(posedge clock_i) if (data_wr_i) ram[data_addr_i] <= data_wdata_i;
endmodule

// ==== dv/tb_cpu_branch_boolean_core.sv ====
// Self-checking bench of the branch and boolean core
module tb_cpu_branch_boolean_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic carry_i = 1'b0;
  logic [1:0] bank_select_i = 2'h0;
  logic [1:0] flash_read_timing_i = 2'h0;
  logic [15:0] code_addr_o, indirect_pointer_o;
  logic [7:0] code_data_i, data_addr_o, data_wdata_o, data_rdata_i;
  logic [7:0] stack_top_o, arith_result_o;
  logic code_rd_o, data_rd_o, data_wr_o, data_sfr_o, carry_wr_o;
  logic carry_o, instr_end_o, irq_exit_o;
  logic [31:0] regs;
  logic [1:0] f;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  mismatches++; $display("wrong value %s exp %0h seen %0h", n, e, s); end end
  assign regs = {stack_top_o, indirect_pointer_o, arith_result_o};
  cbb_core uut (.*);
  cbb_mem mem (.clock_i(clock_i), .code_addr_i(code_addr_o),
    .code_data_o(code_data_i), .data_addr_i(data_addr_o),
    .data_rd_i(data_rd_o), .data_wr_i(data_wr_o),
    .data_wdata_i(data_wdata_o), .data_rdata_o(data_rdata_i));
  always #50 clock_i = ~clock_i;
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  // Relative target from the next instruction address
  function automatic logic [15:0] rel(input logic [15:0] nx,
                                      input logic [7:0] o);
    return nx + {{8{o[7]}}, o};
  endfunction
  // Reset, run one instruction at address 0, check length and target
  task automatic run(input logic [7:0] b0, b1, b2, input logic c,
                     input int n, input logic [15:0] pc, input logic ec);
    int k;
    mem.rom[0] = b0;
    mem.rom[1] = b1;
    mem.rom[2] = b2;
    @(posedge clock_i);
    carry_i <= c;
    flash_read_timing_i <= f;
    bank_select_i <= 2'($urandom);
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    k = 0;
    repeat (12) begin
      @(negedge clock_i);
      k++;
      if (k == 1) `CHK("regs", 32'h07000000, regs)
      if (carry_wr_o === 1'b1) `CHK("carry", ec, carry_o)
      if (instr_end_o === 1'b1) break;
    end
    @(negedge clock_i);
    `CHK("cycles", n, k)
    `CHK("target", pc, code_addr_o)
    @(posedge clock_i);
    resetn_i <= 1'b0;
    @(negedge clock_i);
    $display("test of opcode %h done", b0);
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Random operands, with small counts to hit the zero corners
  initial begin
    logic [7:0] o, v, d, a;
    logic [15:0] t;
    o = 8'($urandom(32'hFCE7));
    f = 2'h0;
    for (int i = 0; i < 3; i++) begin
      o = 8'($urandom);
      t = 16'($urandom);
      d = 8'($urandom_range(127));
      v = 8'($urandom_range(2));
      a = 8'h30 + 8'($urandom_range(79));
      f = 2'(i);
      run(8'h00, 8'h0, 8'h0, 1'b0, 1, 16'h1, 1'bx);
      run(8'hA5, 8'h0, 8'h0, 1'b0, 1, 16'h1, 1'bx);
      run(8'hD3, 8'h0, 8'h0, 1'b0, 1, 16'h1, 1'b1);
      run(8'hB3, 8'h0, 8'h0, 1'b1, 1, 16'h1, 1'b0);
      run(8'hD2, d, 8'h0, 1'b0, 2, 16'h2, 1'bx);
      `CHK("bit", 1'b1, mem.ram[{4'h2, d[6:3]}][d[2:0]])
      run(8'h40, o, 8'h0, 1'b1, 4 + f, rel(16'h2, o), 1'bx);
      run(8'h40, o, 8'h0, 1'b0, 2, 16'h2, 1'bx);
      run(8'h50, o, 8'h0, 1'b0, 4 + f, rel(16'h2, o), 1'bx);
      run(8'h80, o, 8'h0, 1'b1, 4 + f, rel(16'h2, o), 1'bx);
      run({t[10:8], 5'h01}, t[7:0], 8'h0, 1'b0, 4 + f,
        {5'h00, t[10:0]}, 1'bx);
      run(8'h02, t[15:8], t[7:0], 1'b0, 5 + f, t, 1'bx);
      run(8'h12, t[15:8], t[7:0], 1'b0, 5 + f, t, 1'bx);
      `CHK("push", 24'h090003, {stack_top_o, mem.ram[9], mem.ram[8]})
      mem.ram[7] = t[15:8];
      mem.ram[6] = t[7:0];
      run(8'h22, 8'h0, 8'h0, 1'b0, 6 + f, t, 1'bx);
      run(8'h32, 8'h0, 8'h0, 1'b0, 6 + f, t, 1'bx);
      `CHK("pop", 8'h05, stack_top_o)
      for (int j = 0; j < 32; j += 8) mem.ram[j] = v;
      run(8'hD8, o, 8'h0, 1'b0, v == 8'h1 ? 2 : 4 + f,
        v == 8'h1 ? 16'h2 : rel(16'h2, o), 1'bx);
      `CHK("bank", v - 8'h1, mem.ram[{bank_select_i, 3'h0}])
      run(8'h73, 8'h0, 8'h0, 1'b0, 3 + f, 16'h0, 1'bx);
      run(8'h60, o, 8'h0, 1'b0, 4 + f, rel(16'h2, o), 1'bx);
      run(8'h70, o, 8'h0, 1'b0, 2, 16'h2, 1'bx);
      mem.ram[a] = v;
      run(8'hD5, a, o, 1'b0, v == 8'h1 ? 3 : 5 + f,
        v == 8'h1 ? 16'h3 : rel(16'h3, o), 1'bx);
      `CHK("count", v - 8'h1, mem.ram[a])
      run(8'hB4, v, o, 1'b0, v == 8'h0 ? 3 : 6 + f,
        v == 8'h0 ? 16'h3 : rel(16'h3, o), v != 8'h0);
      mem.ram[{4'h2, d[6:3]}][d[2:0]] = 1'b1;
      run(8'h10, d, o, 1'b0, 5 + f, rel(16'h3, o), 1'bx);
      `CHK("clear", 1'b0, mem.ram[{4'h2, d[6:3]}][d[2:0]])
    end
    conclude();
  end
endmodule
